/* src/tcb_device_end.sv */
// trigger sequence counter bus, gapped clock and window register access of the receiver
// Overview of operation
// - accepted trigger drops the clock output pulse that would fall in cycle 0, if any
// - control bit 4 clear disables gapped clock
// - bunch and event halves share 12-bit bus
// - mode 00: event low, strobe cycle 0
// - mode 01: running bunch count, strobe cycle 0
// - mode 10: event low then high
// - mode 11: bunch, event low, event high
// - cycle 0 equals trigger output active cycle
// - no strobes outside a trigger sequence
// - first event after clear is number zero
// - mode 00 spacing three when bus used
// - at most 22 back-to-back triggers
// - mode 01 handles triggers every cycle
// - mode 10 spacing three when bus used
// - mode 11 needs spacing of three
// - index register five bits, plus window
// - window reads/writes the indexed register
// - master writes index before window access
// - two addresses: base times two, plus one
// - counter writes clear instead of loading
// - status write of 5 starts reset
// - status write of 0 clears watchdog flag
// - watchdog reset sets status bit 4
`timescale 1ns/10ps
`default_nettype none
module tcb_device_end (
    input wire logic clock,
    input wire logic arst_n,
    tcb_link_if.dev link,
    input wire logic [tcb_pkg::BASE_W-1:0] busBaseAddress,
    input wire logic watchdogResetEvt,
    input wire logic errorEvt,
    output logic resetProcReq
);
    import tcb_pkg::*;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOW, SEQ_HIGH} tcb_seq_t;

    tcb_seq_t seq_q;
    logic [7:0] ctrl_q;
    logic [INDEX_W-1:0] index_q;
    logic [BUNCH_W-1:0] bunch_q;
    logic [EVENT_W-1:0] event_q, evSnap_q;
    logic [ERR_W-1:0] errCnt_q;
    logic wdogFlag_q, softRst_q;
    logic [HALF_W-1:0] bus_q;
    logic bStr_q, lStr_q, hStr_q;
    logic trigOut_q, phase_q, gapClk_q;
    logic [7:0] rdata_q, readVal;

    function automatic logic hitAddr(input logic [ADDR_W-1:0] addr, input logic [BASE_W-1:0] base,
                                     input logic sel);
        hitAddr = addr == {base, sel};
    endfunction

    logic [1:0] mode;
    logic trig;
    logic wrPtr, wrWin, rdPtr, rdWin;
    logic [7:0] wd;
    logic bunchClr, eventClr, errClr;
    logic [EVENT_W-1:0] evNow;

    assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
    assign trig = link.trigAcceptIn;
    assign wd = link.i2cWdata;
    assign wrPtr = link.i2cWr && hitAddr(link.i2cAddr, busBaseAddress, 1'b0);
    assign wrWin = link.i2cWr && hitAddr(link.i2cAddr, busBaseAddress, 1'b1);
    assign rdPtr = link.i2cRd && hitAddr(link.i2cAddr, busBaseAddress, 1'b0);
    assign rdWin = link.i2cRd && hitAddr(link.i2cAddr, busBaseAddress, 1'b1);
    // counter writes never load data, they only clear
    assign bunchClr = link.bunchCountClearCmd || link.bothCountClearCmd || softRst_q
                      || (wrWin && (index_q == REG_BUNCH_LO || index_q == REG_BUNCH_HI));
    assign eventClr = link.eventCountClearCmd || link.bothCountClearCmd || softRst_q
                      || (wrWin && index_q >= REG_EVENT_0 && index_q <= REG_EVENT_2);
    assign errClr = softRst_q || (wrWin && index_q == REG_ERRCNT);
    // a trigger in the clearing cycle is already event zero
    assign evNow = eventClr ? '0 : event_q;

    // control and index registers
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= CTRL_RESET;
            index_q <= '0;
        end
        else if (softRst_q)
        begin
            ctrl_q <= CTRL_RESET;
            index_q <= '0;
        end
        else
        begin
            if (wrPtr)
                index_q <= wd[INDEX_W-1:0];
            if (wrWin && index_q == REG_CTRL)
                ctrl_q <= wd;
        end
    end

    // status side effects; the watchdog set wins over a clearing write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdogFlag_q <= 1'b0;
            softRst_q <= 1'b0;
        end
        else
        begin
            softRst_q <= wrWin && index_q == REG_STATUS && wd == STATUS_CMD_RESET;
            if (watchdogResetEvt)
                wdogFlag_q <= 1'b1;
            else if (wrWin && index_q == REG_STATUS && wd == STATUS_CMD_CLEAR)
                wdogFlag_q <= 1'b0;
        end
    end

    // bunch, event and error counters
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bunch_q <= '0;
            event_q <= '0;
            evSnap_q <= '0;
            errCnt_q <= '0;
        end
        else
        begin
            bunch_q <= bunchClr ? '0 : bunch_q + 12'h001;
            if (trig)
            begin
                evSnap_q <= evNow;
                event_q <= evNow + 24'h000001;
            end
            else
                event_q <= evNow;
            if (errClr)
                errCnt_q <= '0;
            else if (errorEvt && errCnt_q != 8'hFF)
                errCnt_q <= errCnt_q + 8'h01;
        end
    end

    // counter bus sequencer; bus and strobes register together with the trigger output,
    // so cycle 0 is the cycle in which the trigger output is high
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seq_q <= SEQ_IDLE;
            bus_q <= '0;
            bStr_q <= 1'b0;
            lStr_q <= 1'b0;
            hStr_q <= 1'b0;
            trigOut_q <= 1'b0;
        end
        else
        begin
            trigOut_q <= trig;
            bStr_q <= 1'b0;
            lStr_q <= 1'b0;
            hStr_q <= 1'b0;
            if (trig)
            begin
                // a trigger inside a running sequence restarts it; the bus is then unreliable
                unique case (mode)
                    MODE_EVLOW:
                    begin
                        bus_q <= evNow[HALF_W-1:0];
                        lStr_q <= 1'b1;
                        seq_q <= SEQ_IDLE;
                    end
                    MODE_BUNCH:
                    begin
                        bus_q <= bunch_q;
                        bStr_q <= 1'b1;
                        seq_q <= SEQ_IDLE;
                    end
                    MODE_EVLH:
                    begin
                        bus_q <= evNow[HALF_W-1:0];
                        lStr_q <= 1'b1;
                        seq_q <= SEQ_HIGH;
                    end
                    MODE_FULL:
                    begin
                        bus_q <= bunch_q;
                        bStr_q <= 1'b1;
                        seq_q <= SEQ_LOW;
                    end
                endcase
            end
            else
            begin
                unique case (seq_q)
                    SEQ_LOW:
                    begin
                        bus_q <= evSnap_q[HALF_W-1:0];
                        lStr_q <= 1'b1;
                        seq_q <= SEQ_HIGH;
                    end
                    SEQ_HIGH:
                    begin
                        bus_q <= evSnap_q[EVENT_W-1:HALF_W];
                        hStr_q <= 1'b1;
                        seq_q <= SEQ_IDLE;
                    end
                    SEQ_IDLE:
                        // the bunch mode keeps the bus toggling, which costs power
                        bus_q <= (mode == MODE_BUNCH) ? bunch_q : evSnap_q[HALF_W-1:0];
                endcase
            end
        end
    end

    // gapped clock at half the core rate; its high phase is dropped in trigger cycle 0
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= 1'b0;
            gapClk_q <= 1'b0;
        end
        else
        begin
            phase_q <= !phase_q;
            gapClk_q <= ctrl_q[CTRL_CLKGAP_BIT] && !phase_q && !trig;
        end
    end

    always_comb
    begin
        unique case (index_q)
            REG_CTRL: readVal = ctrl_q;
            REG_BUNCH_LO: readVal = bunch_q[7:0];
            REG_BUNCH_HI: readVal = {4'h0, bunch_q[11:8]};
            REG_EVENT_0: readVal = event_q[7:0];
            REG_EVENT_1: readVal = event_q[15:8];
            REG_EVENT_2: readVal = event_q[23:16];
            REG_ERRCNT: readVal = errCnt_q;
            REG_STATUS: readVal = {3'h0, wdogFlag_q, 4'h0};
            default: readVal = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 8'h00;
        else if (rdWin)
            rdata_q <= readVal;
        else if (rdPtr)
            rdata_q <= {3'h0, index_q};
        else
            rdata_q <= 8'h00;
    end

    assign resetProcReq = softRst_q;
    assign link.i2cRdata = rdata_q;
    assign link.counterOutBus = bus_q;
    assign link.bunchValueStrobe = bStr_q;
    assign link.eventLowStrobe = lStr_q;
    assign link.eventHighStrobe = hStr_q;
    assign link.triggerAcceptOut = trigOut_q;
    assign link.clockWithTriggerGap = gapClk_q;
endmodule
`default_nettype wire

/* common/tcb_pkg.sv */
// shared constants for the trigger counter bus and its register access
package tcb_pkg;
    localparam int BUNCH_W = 12;
    localparam int EVENT_W = 24;
    localparam int HALF_W = 12;
    localparam int INDEX_W = 5;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BASE_W = 6;
    localparam int ERR_W = 8;
    // trigger modes, control bits 1:0
    localparam logic [1:0] MODE_EVLOW = 2'h0;
    localparam logic [1:0] MODE_BUNCH = 2'h1;
    localparam logic [1:0] MODE_EVLH = 2'h2;
    localparam logic [1:0] MODE_FULL = 2'h3;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CLKGAP_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h13;
    // internal register indices behind the window register
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_BUNCH_LO = 5'h01;
    localparam logic [4:0] REG_BUNCH_HI = 5'h02;
    localparam logic [4:0] REG_EVENT_0 = 5'h03;
    localparam logic [4:0] REG_EVENT_1 = 5'h04;
    localparam logic [4:0] REG_EVENT_2 = 5'h05;
    localparam logic [4:0] REG_ERRCNT = 5'h06;
    localparam logic [4:0] REG_STATUS = 5'h07;
    localparam int STATUS_WDOG_BIT = 4;
    localparam logic [7:0] STATUS_CMD_RESET = 8'h05;
    localparam logic [7:0] STATUS_CMD_CLEAR = 8'h00;
    // host command port register addresses
    localparam logic [2:0] HREG_CMD = 3'h0;
    localparam logic [2:0] HREG_BASE = 3'h1;
    localparam logic [2:0] HREG_INDEX = 3'h2;
    localparam logic [2:0] HREG_WDATA = 3'h3;
    localparam logic [2:0] HREG_RDGO = 3'h4;
    localparam logic [2:0] HREG_STAT = 3'h5;
    localparam logic [2:0] HREG_MODE = 3'h6;
    localparam logic [2:0] HREG_RDATA = 3'h7;
    localparam int CMD_TRIG_BIT = 0;
    localparam int CMD_EVCLR_BIT = 1;
    localparam int CMD_BOTHCLR_BIT = 2;
    localparam int CMD_BCLR_BIT = 3;
    // trigger spacing limits in clock cycles
    localparam logic [3:0] SPACE_FAST = 4'h1;
    localparam logic [3:0] SPACE_BUS = 4'h3;
    localparam logic [3:0] SPACE_SAT = 4'hF;
    localparam logic [4:0] MAX_CONSEC = 5'h16;
endpackage

/* common/tcb_link_if.sv */
// link between the trigger counter device and its trigger source and access master
`timescale 1ns/10ps
`default_nettype none
interface tcb_link_if;
    logic trigAcceptIn;
    logic eventCountClearCmd;
    logic bothCountClearCmd;
    logic bunchCountClearCmd;
    logic [6:0] i2cAddr;
    logic i2cWr;
    logic i2cRd;
    logic [7:0] i2cWdata;
    logic [7:0] i2cRdata;
    logic [11:0] counterOutBus;
    logic bunchValueStrobe;
    logic eventLowStrobe;
    logic eventHighStrobe;
    logic triggerAcceptOut;
    logic clockWithTriggerGap;
    modport dev (
        input trigAcceptIn, eventCountClearCmd, bothCountClearCmd, bunchCountClearCmd,
        input i2cAddr, i2cWr, i2cRd, i2cWdata,
        output i2cRdata, counterOutBus, bunchValueStrobe, eventLowStrobe, eventHighStrobe,
        output triggerAcceptOut, clockWithTriggerGap
    );
    modport host (
        output trigAcceptIn, eventCountClearCmd, bothCountClearCmd, bunchCountClearCmd,
        output i2cAddr, i2cWr, i2cRd, i2cWdata,
        input i2cRdata, counterOutBus, bunchValueStrobe, eventLowStrobe, eventHighStrobe,
        input triggerAcceptOut, clockWithTriggerGap
    );
endinterface
`default_nettype wire

/* src/tcb_host_end.sv */
// trigger source and register access master facing the trigger counter device
`timescale 1ns/10ps
`default_nettype none
module tcb_host_end (
    input wire logic clock,
    input wire logic arst_n,
    tcb_link_if.host link,
    input wire logic [2:0] hostAddr,
    input wire logic [7:0] hostWdata,
    input wire logic hostWr,
    input wire logic hostRd,
    output logic [7:0] hostRdata
);
    import tcb_pkg::*;

    typedef enum logic [1:0] {ACC_IDLE, ACC_WIN, ACC_WAIT, ACC_CAPT} tcb_acc_t;

    tcb_acc_t acc_q;
    logic [BASE_W-1:0] base_q;
    logic [INDEX_W-1:0] index_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] mode_q;
    logic opRead_q;
    logic trigRefused_q;
    logic accRefused_q;
    logic [3:0] gap_q;
    logic [4:0] consec_q;
    logic trig_q;
    logic evClr_q;
    logic bothClr_q;
    logic bClr_q;
    logic i2cWr_q;
    logic i2cRd_q;
    logic [ADDR_W-1:0] i2cAddr_q;
    logic [DATA_W-1:0] i2cWdata_q;
    logic [7:0] hostRdata_q;

    function automatic logic [3:0] minSpace(input logic [1:0] mode);
        // counter bus contents are assumed in use, so only the bunch mode may run back to back
        minSpace = (mode == MODE_BUNCH) ? SPACE_FAST : SPACE_BUS;
    endfunction

    logic cmdWr;
    logic trigReq;
    logic trigOk;
    logic goWr;
    logic goRd;
    assign cmdWr = hostWr && hostAddr == HREG_CMD;
    assign trigReq = cmdWr && hostWdata[CMD_TRIG_BIT];
    assign trigOk = gap_q >= minSpace(mode_q) && !(gap_q == SPACE_FAST && consec_q >= MAX_CONSEC);
    assign goWr = hostWr && hostAddr == HREG_WDATA;
    assign goRd = hostWr && hostAddr == HREG_RDGO;

    // trigger issue and spacing bookkeeping
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trig_q <= 1'b0;
            gap_q <= SPACE_SAT;
            consec_q <= 5'h00;
            evClr_q <= 1'b0;
            bothClr_q <= 1'b0;
            bClr_q <= 1'b0;
        end
        else
        begin
            trig_q <= trigReq && trigOk;
            evClr_q <= cmdWr && hostWdata[CMD_EVCLR_BIT];
            bothClr_q <= cmdWr && hostWdata[CMD_BOTHCLR_BIT];
            bClr_q <= cmdWr && hostWdata[CMD_BCLR_BIT];
            if (trigReq && trigOk)
            begin
                gap_q <= SPACE_FAST;
                consec_q <= (gap_q == SPACE_FAST) ? consec_q + 5'h01 : 5'h01;
            end
            else if (gap_q != SPACE_SAT)
                gap_q <= gap_q + 4'h1;
        end
    end

    // command registers and sticky flags, a new refusal beats the clearing write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            base_q <= '0;
            index_q <= '0;
            wdata_q <= '0;
            mode_q <= CTRL_RESET[1:0];
            trigRefused_q <= 1'b0;
            accRefused_q <= 1'b0;
        end
        else
        begin
            if (hostWr && hostAddr == HREG_BASE)
                base_q <= hostWdata[BASE_W-1:0];
            if (hostWr && hostAddr == HREG_INDEX)
                index_q <= hostWdata[INDEX_W-1:0];
            if (goWr && acc_q == ACC_IDLE)
                wdata_q <= hostWdata;
            if (hostWr && hostAddr == HREG_MODE)
                mode_q <= hostWdata[1:0];
            if (trigReq && !trigOk)
                trigRefused_q <= 1'b1;
            else if (hostWr && hostAddr == HREG_STAT)
                trigRefused_q <= 1'b0;
            if ((goWr || goRd) && acc_q != ACC_IDLE)
                accRefused_q <= 1'b1;
            else if (hostWr && hostAddr == HREG_STAT)
                accRefused_q <= 1'b0;
        end
    end

    // two step access: index register first, then the window register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_q <= ACC_IDLE;
            opRead_q <= 1'b0;
            i2cWr_q <= 1'b0;
            i2cRd_q <= 1'b0;
            i2cAddr_q <= '0;
            i2cWdata_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            i2cWr_q <= 1'b0;
            i2cRd_q <= 1'b0;
            unique case (acc_q)
                ACC_IDLE:
                    if (goWr || goRd)
                    begin
                        opRead_q <= goRd;
                        i2cWr_q <= 1'b1;
                        i2cAddr_q <= {base_q, 1'b0};
                        i2cWdata_q <= {3'h0, index_q};
                        acc_q <= ACC_WIN;
                    end
                ACC_WIN:
                begin
                    i2cAddr_q <= {base_q, 1'b1};
                    i2cWr_q <= !opRead_q;
                    i2cRd_q <= opRead_q;
                    i2cWdata_q <= wdata_q;
                    acc_q <= opRead_q ? ACC_WAIT : ACC_IDLE;
                end
                ACC_WAIT:
                    acc_q <= ACC_CAPT;
                ACC_CAPT:
                begin
                    rdata_q <= link.i2cRdata;
                    acc_q <= ACC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            hostRdata_q <= 8'h00;
        else if (hostRd)
            unique case (hostAddr)
                HREG_BASE: hostRdata_q <= {2'h0, base_q};
                HREG_INDEX: hostRdata_q <= {3'h0, index_q};
                HREG_WDATA: hostRdata_q <= wdata_q;
                HREG_STAT: hostRdata_q <= {5'h00, accRefused_q, trigRefused_q, acc_q != ACC_IDLE};
                HREG_MODE: hostRdata_q <= {6'h00, mode_q};
                HREG_RDATA: hostRdata_q <= rdata_q;
                default: hostRdata_q <= 8'h00;
            endcase
        else
            hostRdata_q <= 8'h00;
    end

    assign hostRdata = hostRdata_q;
    assign link.trigAcceptIn = trig_q;
    assign link.eventCountClearCmd = evClr_q;
    assign link.bothCountClearCmd = bothClr_q;
    assign link.bunchCountClearCmd = bClr_q;
    assign link.i2cWr = i2cWr_q;
    assign link.i2cRd = i2cRd_q;
    assign link.i2cAddr = i2cAddr_q;
    assign link.i2cWdata = i2cWdata_q;
endmodule
`default_nettype wire

/* dv/tcb_checker.sv */
// concurrent checks on the link between the trigger source and the counter device
`timescale 1ns/10ps
`default_nettype none
module tcb_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic trigAcceptIn,
    input wire logic bunchCountClearCmd,
    input wire logic [6:0] i2cAddr,
    input wire logic i2cRd,
    input wire logic [7:0] i2cRdata,
    input wire logic [11:0] counterOutBus,
    input wire logic bunchValueStrobe,
    input wire logic eventLowStrobe,
    input wire logic eventHighStrobe,
    input wire logic triggerAcceptOut,
    input wire logic clockWithTriggerGap
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    trig_cycle_zero_a: assert property (trigAcceptIn |=> triggerAcceptOut)
        else $error("trigger output missing after accept");
    gap_drop_a: assert property (trigAcceptIn |=> !clockWithTriggerGap)
        else $error("gapped clock high in trigger cycle 0");
    gap_half_rate_a: assert property (clockWithTriggerGap |=> !clockWithTriggerGap)
        else $error("gapped clock high two cycles running");
    strobe_onehot_a: assert property ($onehot0({bunchValueStrobe, eventLowStrobe, eventHighStrobe}))
        else $error("two counter strobes at once");
    bunch_strobe_a: assert property (bunchValueStrobe |-> triggerAcceptOut)
        else $error("bunch strobe outside cycle 0");
    low_strobe_a: assert property (eventLowStrobe |-> triggerAcceptOut || $past(triggerAcceptOut))
        else $error("event low strobe outside cycles 0 and 1");
    high_after_low_a: assert property (eventHighStrobe |-> $past(eventLowStrobe) && !triggerAcceptOut)
        else $error("event high strobe not right after low strobe");
    full_seq_a: assert property (eventLowStrobe && $past(bunchValueStrobe) && !trigAcceptIn |=> eventHighStrobe)
        else $error("full sequence lacks event high cycle");
    bunch_run_a: assert property ((bunchValueStrobe && !bunchCountClearCmd && !eventLowStrobe) ##1
        (!eventLowStrobe && !trigAcceptIn && !bunchCountClearCmd) |=>
        counterOutBus == $past(counterOutBus) + 12'h001)
        else $error("bunch value on bus not running");
    index_read_a: assert property (i2cRd && !i2cAddr[0] |=> i2cRdata[7:5] == 3'h0)
        else $error("index read wider than five bits");
    rdata_idle_a: assert property (!$past(i2cRd) |-> i2cRdata == 8'h00)
        else $error("read data outside answer cycle");
endmodule
`default_nettype wire

/* dv/trigger_counter_bus_and_regs_tb.sv */
// self-checking bench joining the host end and the device end
`timescale 1ns/10ps
`default_nettype none
module trigger_counter_bus_and_regs_tb;
    import tcb_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] hostAddr = 3'h0;
    logic [7:0] hostWdata = 8'h00;
    logic hostWr = 1'b0;
    logic hostRd = 1'b0;
    logic [7:0] hostRdata;
    logic [5:0] base = 6'h00;
    logic wdogEvt = 1'b0;
    logic errEvt = 1'b0;
    logic resetProcReq;
    logic rdV = 1'b0;
    logic [7:0] rdQ[$];
    logic [11:0] evQ[$];
    logic [23:0] evNext = 24'h0;
    int n_mismatch = 0;
    int tests_run = 0;
    int nBunch = 0;
    int nGap = 0;
    int nReq = 0;
    tcb_link_if link();
    tcb_host_end i_tcb_host_end (.clock(clock), .arst_n(arst_n), .link(link), .hostAddr(hostAddr),
        .hostWdata(hostWdata), .hostWr(hostWr), .hostRd(hostRd), .hostRdata(hostRdata));
    tcb_device_end i_tcb_device_end (.clock(clock), .arst_n(arst_n), .link(link), .busBaseAddress(base),
        .watchdogResetEvt(wdogEvt), .errorEvt(errEvt), .resetProcReq(resetProcReq));
    tcb_checker i_tcb_checker (.clock(clock), .arst_n(arst_n), .trigAcceptIn(link.trigAcceptIn),
        .bunchCountClearCmd(link.bunchCountClearCmd), .i2cAddr(link.i2cAddr), .i2cRd(link.i2cRd),
        .i2cRdata(link.i2cRdata), .counterOutBus(link.counterOutBus), .bunchValueStrobe(link.bunchValueStrobe),
        .eventLowStrobe(link.eventLowStrobe), .eventHighStrobe(link.eventHighStrobe),
        .triggerAcceptOut(link.triggerAcceptOut), .clockWithTriggerGap(link.clockWithTriggerGap));

    always #50 clock = ~clock;

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        // a note left in a queue means an answer that never came
        chk("pending notes", 24'h0, 24'(evQ.size() + rdQ.size()));
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // outputs of flops are read here before this edge's updates land
    always @(posedge clock)
    begin
        if (rdV)
            chk("read data", (rdQ.size() > 0) ? {16'h0, rdQ.pop_front()} : 24'hFFFFFF, {16'h0, hostRdata});
        if (link.eventLowStrobe === 1'b1 || link.eventHighStrobe === 1'b1)
            chk("event half", (evQ.size() > 0) ? {12'h0, evQ.pop_front()} : 24'hFFFFFF, {12'h0, link.counterOutBus});
        rdV <= hostRd;
        // counted late in the step so the stimulus never races the tally
        nBunch <= nBunch + int'(link.bunchValueStrobe === 1'b1);
        nGap <= nGap + int'(link.clockWithTriggerGap === 1'b1);
        nReq <= nReq + int'(resetProcReq === 1'b1);
    end

    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        hostAddr <= a;
        hostWdata <= d;
        hostWr <= 1'b1;
        @(posedge clock);
        hostWr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic hr(input logic [2:0] a, input logic [7:0] exp);
        rdQ.push_back(exp);
        hostAddr <= a;
        hostRd <= 1'b1;
        @(posedge clock);
        hostRd <= 1'b0;
        @(posedge clock);
    endtask

    // a window read keeps the host busy for three cycles after its start
    task automatic dread(input logic [4:0] idx, input logic [7:0] exp);
        hw(HREG_INDEX, {3'h0, idx});
        hw(HREG_RDGO, 8'h00);
        repeat (5) @(posedge clock);
        hr(HREG_RDATA, exp);
    endtask

    task automatic dwrite(input logic [4:0] idx, input logic [7:0] d);
        hw(HREG_INDEX, {3'h0, idx});
        hw(HREG_WDATA, d);
        repeat (3) @(posedge clock);
    endtask

    task automatic setmode(input logic [1:0] m);
        dwrite(REG_CTRL, {6'h04, m});
        hw(HREG_MODE, {6'h0, m});
    endtask

    task automatic trig(input logic [1:0] m);
        if (m != MODE_BUNCH)
            evQ.push_back(evNext[11:0]);
        if (m[1])
            evQ.push_back(evNext[23:12]);
        evNext++;
        hw(HREG_CMD, 8'h01);
        repeat (2) @(posedge clock);
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        int n0;
        void'($urandom(73));
        base <= 6'($urandom());
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        hw(HREG_BASE, {2'h0, base});
        dread(REG_CTRL, CTRL_RESET);
        dread(REG_STATUS, 8'h00);
        n0 = nGap;
        repeat (8) @(posedge clock);
        chk("gap clock highs", 24'h4, 24'(nGap - n0));
        dwrite(REG_CTRL, 8'h03);
        n0 = nGap;
        repeat (8) @(posedge clock);
        chk("gap clock highs off", 24'h0, 24'(nGap - n0));
        hw(HREG_CMD, 8'h02);
        evNext = 24'h0;
        for (int m = 0; m < 4; m++)
        begin
            setmode(2'(m));
            trig(2'(m));
            trig(2'(m));
        end
        setmode(MODE_BUNCH);
        hw(HREG_STAT, 8'h00);
        n0 = nBunch;
        hostAddr <= HREG_CMD;
        hostWdata <= 8'h01;
        hostWr <= 1'b1;
        repeat (23) @(posedge clock);
        hostWr <= 1'b0;
        repeat (4) @(posedge clock);
        evNext += 24'h16;
        chk("bunch strobes", 24'h16, 24'(nBunch - n0));
        hr(HREG_STAT, 8'h02);
        dread(REG_EVENT_0, evNext[7:0]);
        dread(REG_EVENT_1, evNext[15:8]);
        dread(REG_EVENT_2, evNext[23:16]);
        setmode(MODE_FULL);
        hw(HREG_CMD, 8'h04);
        evNext = 24'h0;
        trig(MODE_FULL);
        dwrite(REG_EVENT_0, 8'($urandom()));
        dread(REG_EVENT_0, 8'h00);
        errEvt <= 1'b1;
        repeat (3) @(posedge clock);
        errEvt <= 1'b0;
        @(posedge clock);
        dread(REG_ERRCNT, 8'h03);
        dwrite(REG_ERRCNT, 8'($urandom()));
        dread(REG_ERRCNT, 8'h00);
        // let the bunch count pass 255 so that only the clear can bring the high byte back to zero
        repeat (300) @(posedge clock);
        dwrite(REG_BUNCH_HI, 8'($urandom()));
        dread(REG_BUNCH_HI, 8'h00);
        wdogEvt <= 1'b1;
        @(posedge clock);
        wdogEvt <= 1'b0;
        @(posedge clock);
        dread(REG_STATUS, 8'h10);
        dwrite(REG_STATUS, STATUS_CMD_CLEAR);
        dread(REG_STATUS, 8'h00);
        setmode(MODE_EVLOW);
        n0 = nReq;
        dwrite(REG_STATUS, STATUS_CMD_RESET);
        chk("reset requests", 24'h1, 24'(nReq - n0));
        dread(REG_CTRL, CTRL_RESET);
        hw(HREG_MODE, {6'h0, MODE_FULL});
        // a neighbour's base must see nothing answer
        hw(HREG_BASE, {2'h0, base ^ 6'h01});
        dread(REG_CTRL, 8'h00);
        hw(HREG_BASE, {2'h0, base});
        dread(REG_CTRL, CTRL_RESET);
        repeat (4) @(posedge clock);
        summarize();
    end
endmodule
`default_nettype wire
